// File: adc_result_format_threshold_detect_tb_top.sv
// Self-checking bench for the threshold detecting scan controller.
`default_nettype none
module adc_result_format_threshold_detect_tb_top
   import atd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int          NC = 4;
   localparam logic [1:0]  CMT [4] = '{CM_GREAT, CM_LESS, CM_INSIDE, CM_OUTSIDE};
   localparam logic [1:0]  WMT [4] = '{WM_STORE, WM_DISCARD, WM_DISCARD, WM_DISCARD};
   localparam logic [1:0]  HIT [4] = '{2'h1, 2'h2, 2'h1, 2'h2};
   localparam logic [15:0] B0T [4] = '{16'h00c8, 16'h0064, 16'h0064, 16'h0064};
   localparam logic        IRQT [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic        conv_start, conv_done, converter_irq, low_power_return, scan_busy, lp_seen;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [4:0]  conv_channel, ch_q;
   logic [11:0] conv_code;
   logic [11:0] codes [NC];
   logic [15:0] trig_pins;
   int          num_errors, tests_run, pend;
   assign hready = hreadyout;
   atd_core #(.NUM_CH(NC)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .conv_start(conv_start), .conv_channel(conv_channel), .conv_done(conv_done),
      .conv_code(conv_code), .trig_pins(trig_pins), .converter_irq(converter_irq),
      .low_power_return(low_power_return), .scan_busy(scan_busy));
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Converter stand-in; the code line toggles outside a result so stale data never matches.
   // The low-power pulse latch is cleared by any bus select, so only a pulse after the last access counts.
   always @(posedge hclk) begin
      if (!hresetn) begin
         {conv_done, lp_seen, conv_code, pend} <= '0;
      end else begin
         conv_done <= 1'b0;
         conv_code <= ~conv_code;
         if (low_power_return) lp_seen <= 1'b1;
         else if (hsel) lp_seen <= 1'b0;
         if (conv_start) begin
            ch_q <= conv_channel;
            pend <= 3;
         end else if (pend == 1) begin
            conv_done <= 1'b1;
            conv_code <= codes[ch_q[1:0]];
            pend      <= 0;
         end else if (pend > 1) pend <= pend - 1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {24'h0, a};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rd, exp);
      chk({31'h0, hresp}, 32'h0);
   endtask
   task automatic wait_busy(input logic v, input int lim);
      int n;
      n = 0;
      while (scan_busy !== v && n < lim) begin
         @(posedge hclk);
         n++;
      end
      chk({31'h0, scan_busy}, {31'h0, v});
   endtask
   function automatic logic [15:0] fmt(input logic [11:0] c, input logic r12, input logic [1:0] f);
      case ({r12, f})
         3'b100: return {4'h0, c};
         3'b101: return {{5{~c[11]}}, c[10:0]};
         3'b110: return {c, 4'h0};
         3'b111: return {~c[11], c[10:0], 4'h0};
         3'b000: return {6'h0, c[9:0]};
         3'b001: return {{7{~c[9]}}, c[8:0]};
         3'b010: return {c[9:0], 6'h0};
         default: return {~c[9], c[8:0], 6'h0};
      endcase
   endfunction
   task automatic final_report;
      if (num_errors == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #400000;
      num_errors++;
      final_report();
   end
   initial begin
      {hresetn, hsel, hwrite, haddr, hwdata, htrans, trig_pins} = '0;
      {num_errors, tests_run} = '0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      rdc(OFS_CTL_LO, 32'h0);
      rdc(OFS_HIT_LO, 32'h0);
      rdc(8'h24, 32'h0);
      rdc(OFS_BUF_BASE + 8'(4 * NC), 32'h0);
      xfer(1'b1, OFS_BUF_CTL, 32'hc);
      xfer(1'b1, OFS_SEL_LO, 32'hf);
      codes = '{12'hfff, 12'h800, 12'h200, 12'h001};
      for (int r = 0; r < 2; r++) for (int f = 0; f < 4; f++) begin
         xfer(1'b1, OFS_CONV_CTL, 32'(32'h101 | (f << 1) | (r << 3)));
         wait_busy(1'b1, 20);
         wait_busy(1'b0, 500);
         for (int c = 0; c < NC; c++) rdc(OFS_BUF_BASE + 8'(4 * c), {16'h0, fmt(codes[c], r[0], 2'(f))});
         chk({31'h0, converter_irq}, 32'h1);
         rdc(OFS_HIT_LO, 32'h0);
         xfer(1'b1, OFS_STATUS, 32'h1);
      end
      codes = '{12'hc8, 12'h32, 12'h0, 12'h0};
      for (int i = 0; i < 4; i++) begin
         xfer(1'b1, OFS_CONV_CTL, 32'h38);
         for (int c = 0; c < NC; c++) xfer(1'b1, OFS_BUF_BASE + 8'(4 * c), (c < 2) ? 32'h64 : 32'h12c);
         xfer(1'b1, OFS_SEL_LO, 32'h3);
         xfer(1'b1, OFS_CTL_LO, {24'h0, 4'h8, WMT[i], CMT[i]});
         xfer(1'b1, OFS_CTL_HI, {24'h0, 6'h10, 2'(i)});
         xfer(1'b1, OFS_CONV_CTL, 32'h39);
         trig_pins <= 16'h0008;
         wait_busy(1'b1, 20);
         trig_pins <= 16'h0000;
         wait_busy(1'b0, 500);
         rdc(OFS_HIT_LO, {30'h0, HIT[i]});
         rdc(OFS_BUF_BASE, {16'h0, B0T[i]});
         chk({31'h0, converter_irq}, {31'h0, IRQT[i]});
         xfer(1'b1, OFS_HIT_LO, 32'hffff_ffff);
         rdc(OFS_HIT_LO, 32'h0);
         xfer(1'b1, OFS_STATUS, 32'h1);
         repeat (3) @(posedge hclk);
         chk({31'h0, lp_seen}, {31'h0, IRQT[i]});
      end
      repeat (30) @(posedge hclk);
      chk({31'h0, scan_busy}, 32'h0);
      xfer(1'b1, OFS_BUF_BASE, 32'h55);
      rdc(OFS_BUF_BASE, 32'h64);
      final_report();
   end
endmodule
`default_nettype wire

// File: atd_core.sv
// Threshold detecting scan controller with result buffer behind an AHB-Lite slave.
// Function
// - 12-bit fractional: code in bits 15:4; signed variant inverts the top bit.
// - 10-bit integer zero-extends; signed integer inverts top bit and sign-extends.
// - 10-bit fractional: code in bits 15:6; signed variant inverts the top bit.
// - Match conditions on conversions can raise the converter interrupt.
// - Buffer is read/write for results and thresholds; hits shown in hit registers.
// - Threshold detect enable bit 7 switches threshold detection on or off.
// - Each set scan select bit adds its channel to the sequential scan.
// - Legacy scan plus threshold enable gives one scan per chosen trigger.
// - Legacy auto-scan depends only on the legacy scan enable bit 2.
// - Comparisons continue in Sleep or Idle; the interrupt wakes the processor.
// - Low-power return enable bit 6 returns to low power after servicing.
// - Compare type selects greater, less, inside window or outside window.
// - Write select: discard after compare, store after compare, or store uncompared.
// - Storing modes use indexed, single FIFO or split FIFO buffering.
// - Compare code 01 tests greater, 00 tests less than the channel threshold.
// - On a simple match, mode 01 replaces the threshold, mode 10 discards.
// - A channel hit bit sets on its event and holds until software clears it.
// - Interrupt mode selects per scan, scan with match, on match, or never.
//
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`default_nettype none
module atd_core
   import atd_pkg::*;
#(
   parameter int NUM_CH = 32
)(
   // Clock and reset.
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave.
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   // Analog converter handshake.
   output logic             conv_start,
   output logic      [4:0]  conv_channel,
   input  wire logic        conv_done,
   input  wire logic [11:0] conv_code,
   // Trigger pins and system signals.
   input  wire logic [15:0] trig_pins,
   output logic             converter_irq,
   output logic             low_power_return,
   output logic             scan_busy
);
   localparam int CW   = $clog2(NUM_CH);
   localparam int HALF = NUM_CH / 2;
   ////////////////////////////////////////////////////////////////////////////////
   logic [7:0]        ctl_lo;
   logic [7:0]        ctl_hi;
   logic [3:0]        buf_ctl;
   logic [7:0]        conv_ctl;
   logic [31:0]       scan_sel;
   logic [31:0]       hits;
   logic              irq_flag;
   logic [15:0]       mem [NUM_CH];
   logic              a_wr;
   logic              a_rd;
   logic [11:0]       a_addr;
   logic              rd_wait;
   logic [15:0]       trig_s1;
   logic [15:0]       trig_s2;
   logic [15:0]       trig_s3;
   logic              sw_start;
   atd_state_e        st;
   logic [CW-1:0]     ch_idx;
   logic [15:0]       cmp_val;
   logic              scan_match;
   logic [CW-1:0]     fifo_ptr;
   logic              buf_half;
   logic [15:0]       fmt_val;
   wire logic         threshold_detect_enable   = ctl_lo[TDE_BIT];
   wire logic [1:0]   result_write_select       = ctl_lo[WM_LSB+:2];
   wire logic [1:0]   compare_type_select       = ctl_lo[CM_LSB+:2];
   wire logic         low_power_return_enable   = ctl_hi[LPR_BIT];
   wire logic [1:0]   threshold_irq_mode_select = ctl_hi[IRQM_LSB+:2];
   wire logic         channel_indexed_select    = buf_ctl[CIDX_BIT];
   wire logic         legacy_scan_enable        = buf_ctl[LSCAN_BIT];
   wire logic         split_buffer_select       = buf_ctl[SPLIT_BIT];
   wire logic         threshold_detect_on       = conv_ctl[ON_BIT];
   wire logic [1:0]   form                      = conv_ctl[FORM_LSB+:2];
   wire logic         res12                     = conv_ctl[RES12_BIT];
   wire logic [3:0]   conversion_trigger_source = conv_ctl[TSRC_LSB+:4];
   ////////////////////////////////////////////////////////////////////////////////
   // Reads take one wait state so that read data always come from a flip-flop.
   wire logic         a_phase   = hsel && htrans[1] && hready;
   wire logic         reg_space = (a_addr[11:8] == 4'h0);
   wire logic         buf_hit   = reg_space && a_addr[7] && (32'(a_addr[6:2]) < NUM_CH);
   wire logic [CW-1:0] buf_ix   = CW'(a_addr[6:2]);
   wire logic         wr_now    = a_wr;
   wire logic         wr_ctl_lo = wr_now && reg_space && (a_addr[7:0] == OFS_CTL_LO);
   wire logic         wr_ctl_hi = wr_now && reg_space && (a_addr[7:0] == OFS_CTL_HI);
   wire logic         wr_bufctl = wr_now && reg_space && (a_addr[7:0] == OFS_BUF_CTL);
   wire logic         wr_conv   = wr_now && reg_space && (a_addr[7:0] == OFS_CONV_CTL);
   wire logic         wr_sel_lo = wr_now && reg_space && (a_addr[7:0] == OFS_SEL_LO);
   wire logic         wr_sel_hi = wr_now && reg_space && (a_addr[7:0] == OFS_SEL_HI);
   wire logic         wr_hit_lo = wr_now && reg_space && (a_addr[7:0] == OFS_HIT_LO);
   wire logic         wr_hit_hi = wr_now && reg_space && (a_addr[7:0] == OFS_HIT_HI);
   wire logic         wr_status = wr_now && reg_space && (a_addr[7:0] == OFS_STATUS);
   // Thresholds may only be loaded while the converter is off, so a scan never races software.
   wire logic         sw_buf_we = wr_now && buf_hit && !threshold_detect_on;
   wire logic [31:0]  hit_clr   = {wr_hit_hi ? hwdata[15:0] : 16'h0000, wr_hit_lo ? hwdata[15:0] : 16'h0000};
   wire logic [31:0]  status_w  = {29'h0, scan_busy, buf_half, irq_flag};
   wire logic [31:0]  rd_mux    =
      !reg_space                     ? 32'h0000_0000 :
      buf_hit                        ? {16'h0000, mem[buf_ix]} :
      (a_addr[7:0] == OFS_CTL_LO)    ? {24'h0, ctl_lo} :
      (a_addr[7:0] == OFS_CTL_HI)    ? {24'h0, ctl_hi} :
      (a_addr[7:0] == OFS_BUF_CTL)   ? {28'h0, buf_ctl} :
      (a_addr[7:0] == OFS_CONV_CTL)  ? {24'h0, conv_ctl} :
      (a_addr[7:0] == OFS_SEL_LO)    ? {16'h0, scan_sel[15:0]} :
      (a_addr[7:0] == OFS_SEL_HI)    ? {16'h0, scan_sel[31:16]} :
      (a_addr[7:0] == OFS_HIT_LO)    ? {16'h0, hits[15:0]} :
      (a_addr[7:0] == OFS_HIT_HI)    ? {16'h0, hits[31:16]} :
      (a_addr[7:0] == OFS_STATUS)    ? status_w : 32'h0000_0000;
   assign hreadyout = !rd_wait;
   assign hresp     = 1'b0;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_wr    <= 1'b0;
         a_rd    <= 1'b0;
         a_addr  <= 12'h000;
         rd_wait <= 1'b0;
         hrdata  <= 32'h0000_0000;
      end else begin
         if (hready) begin
            a_wr   <= a_phase && hwrite;
            a_rd   <= a_phase && !hwrite;
            a_addr <= haddr[11:0];
         end
         rd_wait <= a_phase && !hwrite;
         if (rd_wait) begin
            hrdata <= rd_mux;
         end
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctl_lo   <= RST_CTL_LO;
         ctl_hi   <= RST_CTL_HI;
         buf_ctl  <= RST_BUF_CTL;
         conv_ctl <= RST_CONV_CTL;
         scan_sel <= RST_SEL;
         sw_start <= 1'b0;
      end else begin
         if (wr_ctl_lo) ctl_lo <= hwdata[7:0];
         if (wr_ctl_hi) ctl_hi <= hwdata[7:0];
         if (wr_bufctl) buf_ctl <= hwdata[3:0];
         if (wr_conv) conv_ctl <= hwdata[7:0];
         if (wr_sel_lo) scan_sel[15:0] <= hwdata[15:0];
         if (wr_sel_hi) scan_sel[31:16] <= hwdata[15:0];
         sw_start <= wr_conv && hwdata[SWSTART_BIT];
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Trigger pins are asynchronous; the edge detector compares the second and third stages, never the first.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trig_s1 <= 16'h0000;
         trig_s2 <= 16'h0000;
         trig_s3 <= 16'h0000;
      end else begin
         trig_s1 <= trig_pins;
         trig_s2 <= trig_s1;
         trig_s3 <= trig_s2;
      end
   end
   wire logic [15:0] trig_rise = trig_s2 & ~trig_s3;
   wire logic trig_evt = (conversion_trigger_source == 4'h0) ? sw_start : trig_rise[conversion_trigger_source];
   // Without legacy scanning only channel 0 is converted; the threshold enable has no say here.
   wire logic [31:0] eff_sel  = legacy_scan_enable ? scan_sel : 32'h0000_0001;
   wire logic        sel_now  = eff_sel[ch_idx];
   wire logic        last_ch  = (ch_idx == CW'(NUM_CH - 1));
   wire logic        cmp_en   = threshold_detect_enable && (result_write_select != WM_LEGACY);
   ////////////////////////////////////////////////////////////////////////////////
   // Signed formats compare correctly as unsigned once their top bits are flipped.
   wire logic        sgn      = form[0];
   wire logic [CW-1:0] mir_ix = CW'(32'(ch_idx) + HALF);
   wire logic [15:0] key_v    = {cmp_val[15] ^ sgn, cmp_val[14:0]};
   wire logic [15:0] key_lo   = {mem[ch_idx][15] ^ sgn, mem[ch_idx][14:0]};
   wire logic [15:0] key_hi   = {mem[mir_ix][15] ^ sgn, mem[mir_ix][14:0]};
   wire logic        in_win   = (key_v >= key_lo) && (key_v <= key_hi);
   wire logic        cond     = (compare_type_select == CM_GREAT)  ? (key_v > key_lo) :
                                (compare_type_select == CM_LESS)   ? (key_v < key_lo) :
                                (compare_type_select == CM_INSIDE) ? in_win : !in_win;
   wire logic        in_eval  = (st == ATD_EVAL);
   wire logic        match    = in_eval && cmp_en && cond;
   wire logic        store    = in_eval && (!cmp_en || (result_write_select == WM_STORE && cond));
   wire logic [CW-1:0] fifo_ix = split_buffer_select ? {buf_half, fifo_ptr[CW-2:0]} : fifo_ptr;
   wire logic [CW-1:0] st_ix  = channel_indexed_select ? ch_idx : fifo_ix;
   wire logic        scan_end = in_eval && last_ch || (st == ATD_SEEK) && !sel_now && last_ch;
   assign conv_start   = (st == ATD_SEEK) && sel_now;
   assign conv_channel = 5'(ch_idx);
   assign scan_busy    = (st != ATD_IDLE);
   atd_format u_format (
      .code  (conv_code),
      .res12 (res12),
      .form  (form),
      .value (fmt_val)
   );
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st         <= ATD_IDLE;
         ch_idx     <= '0;
         cmp_val    <= 16'h0000;
         scan_match <= 1'b0;
      end else begin
         case (st)
            ATD_IDLE: begin
               ch_idx     <= '0;
               scan_match <= 1'b0;
               if (trig_evt && threshold_detect_on) st <= ATD_SEEK;
            end
            ATD_SEEK: begin
               if (sel_now) st <= ATD_CONV;
               else if (last_ch) st <= ATD_IDLE;
               else ch_idx <= ch_idx + 1'b1;
            end
            ATD_CONV: begin
               if (conv_done) begin
                  cmp_val <= fmt_val;
                  st      <= ATD_EVAL;
               end
            end
            ATD_EVAL: begin
               scan_match <= scan_match || match;
               if (last_ch) st <= ATD_IDLE;
               else begin
                  ch_idx <= ch_idx + 1'b1;
                  st     <= ATD_SEEK;
               end
            end
            default: st <= ATD_IDLE;
         endcase
      end
   end
   // One scan per trigger: the FSM parks in idle after the last channel.
   always_ff @(posedge hclk) begin
      if (store) mem[st_ix] <= cmp_val;
      else if (sw_buf_we) mem[buf_ix] <= hwdata[15:0];
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fifo_ptr <= '0;
         buf_half <= 1'b0;
      end else if (scan_end) begin
         fifo_ptr <= '0;
         buf_half <= split_buffer_select ? !buf_half : 1'b0;
      end else if (store && !channel_indexed_select) begin
         fifo_ptr <= fifo_ptr + 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Hit and interrupt flags: a hardware set in the same cycle as a clear wins.
   wire logic [31:0] hit_set = match ? (32'h1 << ch_idx) : 32'h0;
   wire logic irq_set = threshold_detect_enable ?
      ((threshold_irq_mode_select == IM_SCAN) && scan_end ||
       (threshold_irq_mode_select == IM_SCANHIT) && scan_end && (scan_match || match) ||
       (threshold_irq_mode_select == IM_MATCH) && match) : scan_end;
   wire logic irq_clr = wr_status && hwdata[IRQF_BIT];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hits             <= 32'h0000_0000;
         irq_flag         <= 1'b0;
         low_power_return <= 1'b0;
      end else begin
         hits             <= hit_set | (hits & ~hit_clr);
         irq_flag         <= irq_set || (irq_flag && !irq_clr);
         low_power_return <= irq_flag && irq_clr && !irq_set && low_power_return_enable
                             && threshold_detect_enable;
      end
   end
   // The flag is not gated by any sleep state, so it doubles as the wake request.
   assign converter_irq = irq_flag;
   ////////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   AST_HIT_HOLD: assert property ((hit_clr == 32'h0) |=> ((hits & $past(hits)) == $past(hits)))
      else $error("hit bit dropped without software clear");
   AST_OFF_NO_HIT: assert property (in_eval && !threshold_detect_enable |=> hits == ($past(hits) & ~$past(hit_clr)))
      else $error("hit changed with threshold detect off");
   AST_OFF_STORES: assert property (in_eval && !threshold_detect_enable |-> store && !match)
      else $error("disabled detect did not store plainly");
   AST_FMT_SFRAC12: assert property (res12 && form == FORM_SFRAC |-> fmt_val == {~conv_code[11], conv_code[10:0], 4'h0})
      else $error("12-bit signed fractional wrong");
   AST_FMT_SINT10: assert property (!res12 && form == FORM_SINT |-> $signed(fmt_val) == $signed({7'h00, conv_code[9:0]}) - 17'sd512)
      else $error("10-bit signed integer wrong");
   AST_FMT_FRAC10: assert property (!res12 && form == FORM_FRAC |-> fmt_val[5:0] == 6'h00 && fmt_val[15:6] == conv_code[9:0])
      else $error("10-bit fractional wrong");
   AST_IRQ_MATCH: assert property (match && threshold_detect_enable && threshold_irq_mode_select == IM_MATCH |=> converter_irq)
      else $error("immediate match interrupt missing");
   AST_DISCARD: assert property (in_eval && cmp_en && result_write_select == WM_DISCARD |-> !store)
      else $error("discard mode stored a conversion");
   AST_ONLY_SELECTED: assert property (conv_start |-> eff_sel[ch_idx] ##1 st == ATD_CONV)
      else $error("conversion on an unselected channel");
   AST_GREATER: assert property (match && compare_type_select == CM_GREAT |-> key_v > key_lo)
      else $error("greater compare matched wrongly");
   AST_LP_RETURN: assert property ($fell(irq_flag) && $past(low_power_return_enable && threshold_detect_enable) |-> low_power_return)
      else $error("no low power return after service");
   COV_SCAN_HIT: cover property (scan_end && (scan_match || match));
   COV_WINDOW: cover property (match && compare_type_select == CM_INSIDE);
   COV_SPLIT: cover property (scan_end && split_buffer_select && buf_half);
endmodule
`default_nettype wire

// File: atd_format.sv
// Turns a raw 10- or 12-bit conversion code into one of four 16-bit result formats.
`default_nettype none
module atd_format
   import atd_pkg::*;
(
   // Raw code and format selection.
   input  wire logic [11:0] code,
   input  wire logic        res12,
   input  wire logic [1:0]  form,
   // Formatted result.
   output logic      [15:0] value
);
   wire logic [9:0]  c10      = code[9:0];
   wire logic [15:0] int12    = {4'h0, code};
   wire logic [15:0] sint12   = {{5{~code[11]}}, code[10:0]};
   wire logic [15:0] frac12   = {code, 4'h0};
   wire logic [15:0] sfrac12  = {~code[11], code[10:0], 4'h0};
   wire logic [15:0] int10    = {6'h00, c10};
   wire logic [15:0] sint10   = {{7{~c10[9]}}, c10[8:0]};
   wire logic [15:0] frac10   = {c10, 6'h00};
   wire logic [15:0] sfrac10  = {~c10[9], c10[8:0], 6'h00};
   wire logic [15:0] v12      = (form == FORM_INT)  ? int12 :
                                (form == FORM_SINT) ? sint12 :
                                (form == FORM_FRAC) ? frac12 : sfrac12;
   wire logic [15:0] v10      = (form == FORM_INT)  ? int10 :
                                (form == FORM_SINT) ? sint10 :
                                (form == FORM_FRAC) ? frac10 : sfrac10;
   assign value = res12 ? v12 : v10;
endmodule
`default_nettype wire

// File: atd_pkg.sv
// Shared constants for the converter result formatter and threshold detector.
`default_nettype none
package atd_pkg;
   // Register byte offsets.
   localparam logic [7:0] OFS_CTL_LO    = 8'h00;
   localparam logic [7:0] OFS_CTL_HI    = 8'h04;
   localparam logic [7:0] OFS_BUF_CTL   = 8'h08;
   localparam logic [7:0] OFS_CONV_CTL  = 8'h0c;
   localparam logic [7:0] OFS_SEL_LO    = 8'h10;
   localparam logic [7:0] OFS_SEL_HI    = 8'h14;
   localparam logic [7:0] OFS_HIT_LO    = 8'h18;
   localparam logic [7:0] OFS_HIT_HI    = 8'h1c;
   localparam logic [7:0] OFS_STATUS    = 8'h20;
   localparam logic [7:0] OFS_BUF_BASE  = 8'h80;
   // Field positions.
   localparam int TDE_BIT      = 7;
   localparam int WM_LSB       = 2;
   localparam int CM_LSB       = 0;
   localparam int LPR_BIT      = 6;
   localparam int IRQM_LSB     = 0;
   localparam int CIDX_BIT     = 3;
   localparam int LSCAN_BIT    = 2;
   localparam int SPLIT_BIT    = 1;
   localparam int ON_BIT       = 0;
   localparam int FORM_LSB     = 1;
   localparam int RES12_BIT    = 3;
   localparam int TSRC_LSB     = 4;
   localparam int SWSTART_BIT  = 8;
   localparam int IRQF_BIT     = 0;
   localparam int HALF_BIT     = 1;
   localparam int BUSY_BIT     = 2;
   // Reset values.
   localparam logic [7:0]  RST_CTL_LO   = 8'h00;
   localparam logic [7:0]  RST_CTL_HI   = 8'h00;
   localparam logic [3:0]  RST_BUF_CTL  = 4'h0;
   localparam logic [7:0]  RST_CONV_CTL = 8'h00;
   localparam logic [31:0] RST_SEL      = 32'h0000_0000;
   // Field encodings.
   localparam logic [1:0] CM_LESS   = 2'h0;
   localparam logic [1:0] CM_GREAT  = 2'h1;
   localparam logic [1:0] CM_INSIDE = 2'h2;
   localparam logic [1:0] CM_OUTSIDE = 2'h3;
   localparam logic [1:0] WM_LEGACY  = 2'h0;
   localparam logic [1:0] WM_STORE   = 2'h1;
   localparam logic [1:0] WM_DISCARD = 2'h2;
   localparam logic [1:0] IM_SCAN    = 2'h0;
   localparam logic [1:0] IM_SCANHIT = 2'h1;
   localparam logic [1:0] IM_MATCH   = 2'h2;
   localparam logic [1:0] FORM_INT   = 2'h0;
   localparam logic [1:0] FORM_SINT  = 2'h1;
   localparam logic [1:0] FORM_FRAC  = 2'h2;
   localparam logic [1:0] FORM_SFRAC = 2'h3;
   typedef enum logic [3:0] {
      ATD_IDLE = 4'b0001,
      ATD_SEEK = 4'b0010,
      ATD_CONV = 4'b0100,
      ATD_EVAL = 4'b1000
   } atd_state_e;
endpackage
`default_nettype wire
